// [src/rcos_pkg.sv]
// Package: register map, field positions and constants of the reference clock block
package rcos_pkg;
   // ----------------------------------------------------------------
   // Register byte addresses
   // ----------------------------------------------------------------
   localparam logic [3:0] RCOS_ADDR_CTRL = 4'h0;
   localparam logic [3:0] RCOS_ADDR_STAT = 4'h4;
   localparam logic [3:0] RCOS_ADDR_IRQ_STATUS = 4'h8;
   localparam logic [3:0] RCOS_ADDR_IRQ_MASK = 4'hc;
   // ----------------------------------------------------------------
   // Control register fields
   // ----------------------------------------------------------------
   localparam int RCOS_DIV_LSB = 16;
   localparam int RCOS_DIV_MSB = 30;
   localparam int RCOS_ON_BIT = 15;
   localparam int RCOS_STOP_IN_IDLE_BIT = 13;
   localparam int RCOS_OE_BIT = 12;
   localparam int RCOS_RUN_IN_SLEEP_BIT = 11;
   localparam int RCOS_SWEN_BIT = 9;
   localparam int RCOS_ACT_BIT = 8;
   localparam logic [31:0] RCOS_CTRL_WMASK = 32'h7fff_ba0f;
   localparam logic [31:0] RCOS_CTRL_RESET = 32'h0000_0000;
   localparam logic [3:0] RCOS_SEL_ZERO = 4'h0;
   // ----------------------------------------------------------------
   // Status register field positions and interrupt events
   // ----------------------------------------------------------------
   localparam logic [7:0] RCOS_STAT_MASK = 8'hb7;
   localparam int RCOS_NEVT = 3;
   localparam int RCOS_EVT_SWDONE = 0;
   localparam int RCOS_EVT_ACTCHG = 1;
   localparam int RCOS_EVT_PLLLOSS = 2;
   // ----------------------------------------------------------------
   // AXI responses
   // ----------------------------------------------------------------
   localparam logic [1:0] RCOS_RESP_OKAY = 2'h0;
   localparam logic [1:0] RCOS_RESP_SLVERR = 2'h2;
   // ----------------------------------------------------------------
   // Divider switch state machine
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      RCOS_SW_IDLE = 2'b00,
      RCOS_SW_WAIT = 2'b01,
      RCOS_SW_LOAD = 2'b11
   } rcos_sw_e;
endpackage

// [src/rcos_refclk.sv]
// Reference clock generator with oscillator readiness status over AXI4-Lite
//
// The address map and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ns
// Summary of operation
// - Divide source by twice the 15-bit field 30:16; zero passes source undivided.
// - Bit 15 enables the reference oscillator module.
// - Stop-in-idle bit 13 halts the module during Idle.
// - Bit 12 gates reference clock onto output pin.
// - Run-in-sleep bit 11 keeps output running in Sleep, else disabled.
// - Run-in-sleep has no effect when source select is zero.
// - Software sets bit 9 to switch divider; hardware clears it when done.
// - Read-only bit 8 shows whether reference request is active.
// - Control bits 31, 14, 10 and 7:4 read as zero.
// - Status bit 7 shows PLL locked.
// - Status bits 5 and 4 show low-power RC and secondary ready.
// - Status bits 2,1,0 show primary, postscaler and fast RC ready.
// - Status bits 31:8, 6, 3 read zero; register read-only.
module rcos_refclk
   import rcos_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address and data
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Source clock levels, sampled as data, and power modes
   input wire logic [15:0] src_clk_levels,
   input wire logic idle_mode,
   input wire logic sleep_mode,
   // Oscillator readiness inputs
   input wire logic pll_lock_flag,
   input wire logic low_power_rc_ready,
   input wire logic secondary_osc_ready,
   input wire logic primary_osc_ready,
   input wire logic pll_postscaler_ready,
   input wire logic fast_rc_ready,
   // Reference clock pin and interrupt
   output logic ref_clock_out_pin,
   output logic ref_clock_out_oe,
   output logic irq
);
   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [31:0] ctrl_ff, w_data_ff, wmask, wr_val, rd_val;
   logic [14:0] div_active_ff, div_cnt_ff, div_cfg;
   logic [7:0] stat_ff;
   logic [RCOS_NEVT-1:0] irq_status_ff, irq_mask_ff, evt;
   logic [3:0] aw_addr_ff, w_strb_ff, sel;
   rcos_sw_e sw_state_ff;
   logic ref_ff, src_prev_ff, active_ff, aw_have_ff, w_have_ff, sw_done;
   logic wr_fire, wr_ctrl, wr_irqs, wr_irqm, wr_ok, src_sel, run_en, src_rise, rd_ok;
   assign sel = ctrl_ff[3:0];
   assign div_cfg = ctrl_ff[RCOS_DIV_MSB:RCOS_DIV_LSB];
   // ----------------------------------------------------------------
   // AXI write channel capture
   // ----------------------------------------------------------------
   // Address and data may arrive in either order; each is held until both exist
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_ff <= 1'b0;
         aw_addr_ff <= 4'h0;
         s_axi_awready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_have_ff && !s_axi_awready && s_axi_awvalid && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_ff <= 1'b1;
            aw_addr_ff <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_have_ff <= 1'b0;
         end
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_have_ff <= 1'b0;
         w_data_ff <= 32'h0000_0000;
         w_strb_ff <= 4'h0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_wready <= !w_have_ff && !s_axi_wready && s_axi_wvalid && !s_axi_bvalid;
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_ff <= 1'b1;
            w_data_ff <= s_axi_wdata;
            w_strb_ff <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_have_ff <= 1'b0;
         end
      end
   end
   // Write decode
   always_comb begin
      wr_fire = aw_have_ff && w_have_ff && !s_axi_bvalid;
      for (int i = 0; i < 4; i++) begin
         wmask[i*8 +: 8] = {8{w_strb_ff[i]}};
      end
      wr_val = w_data_ff & wmask;
      wr_ctrl = 1'b0;
      wr_irqs = 1'b0;
      wr_irqm = 1'b0;
      wr_ok = 1'b1;
      if (aw_addr_ff == RCOS_ADDR_CTRL) begin
         wr_ctrl = wr_fire;
      end else if (aw_addr_ff == RCOS_ADDR_STAT) begin
         wr_ok = 1'b1;
      end else if (aw_addr_ff == RCOS_ADDR_IRQ_STATUS) begin
         wr_irqs = wr_fire;
      end else if (aw_addr_ff == RCOS_ADDR_IRQ_MASK) begin
         wr_irqm = wr_fire;
      end else begin
         wr_ok = 1'b0;
      end
   end
   // Write response, status register writes are silently ignored
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RCOS_RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_ok ? RCOS_RESP_OKAY : RCOS_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end
   // ----------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------
   // Writable bits only; unimplemented and status bits stay zero here
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_ff <= RCOS_CTRL_RESET;
      end else begin
         if (wr_ctrl) begin
            ctrl_ff <= (ctrl_ff & ~(wmask & RCOS_CTRL_WMASK)) | (wr_val & RCOS_CTRL_WMASK);
         end
         // Hardware clear wins only when no new request is written at once
         if (sw_done && !(wr_ctrl && wr_val[RCOS_SWEN_BIT])) begin
            ctrl_ff[RCOS_SWEN_BIT] <= 1'b0;
         end
      end
   end
   // ----------------------------------------------------------------
   // Divider switch handshake
   // ----------------------------------------------------------------
   // Waits for a low output phase so the new ratio cannot glitch the pin
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sw_state_ff <= RCOS_SW_IDLE;
         div_active_ff <= 15'h0000;
      end else begin
         case (sw_state_ff)
            RCOS_SW_IDLE: begin
               if (ctrl_ff[RCOS_SWEN_BIT]) begin
                  sw_state_ff <= RCOS_SW_WAIT;
               end
            end
            RCOS_SW_WAIT: begin
               if (!ref_ff || !run_en) begin
                  sw_state_ff <= RCOS_SW_LOAD;
               end
            end
            RCOS_SW_LOAD: begin
               div_active_ff <= div_cfg;
               sw_state_ff <= RCOS_SW_IDLE;
            end
            default: begin
               sw_state_ff <= RCOS_SW_IDLE;
            end
         endcase
      end
   end
   assign sw_done = (sw_state_ff == RCOS_SW_LOAD);
   // ----------------------------------------------------------------
   // Run qualification
   // ----------------------------------------------------------------
   // Idle stop sleep with run-in-sleep ignored for zero source
   always_comb begin
      run_en = ctrl_ff[RCOS_ON_BIT];
      if (idle_mode && ctrl_ff[RCOS_STOP_IN_IDLE_BIT]) begin
         run_en = 1'b0;
      end
      if (sleep_mode && (sel == RCOS_SEL_ZERO || !ctrl_ff[RCOS_RUN_IN_SLEEP_BIT])) begin
         run_en = 1'b0;
      end
      src_sel = src_clk_levels[sel];
      src_rise = src_sel && !src_prev_ff;
   end
   // Request active follows the enable with one cycle of delay
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         active_ff <= 1'b0;
      end else begin
         active_ff <= run_en;
      end
   end
   // ----------------------------------------------------------------
   // Divider
   // ----------------------------------------------------------------
   // Toggles every div edges of the source, giving source over twice div
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         src_prev_ff <= 1'b0;
         div_cnt_ff <= 15'h0000;
         ref_ff <= 1'b0;
      end else begin
         src_prev_ff <= src_sel;
         if (!run_en) begin
            div_cnt_ff <= 15'h0000;
            ref_ff <= 1'b0;
         end else if (div_active_ff == 15'h0000) begin
            ref_ff <= src_sel;
         end else if (src_rise) begin
            if (div_cnt_ff + 15'h0001 >= div_active_ff) begin
               div_cnt_ff <= 15'h0000;
               ref_ff <= !ref_ff;
            end else begin
               div_cnt_ff <= div_cnt_ff + 15'h0001;
            end
         end
      end
   end
   // Output pin gated by output enable
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ref_clock_out_pin <= 1'b0;
         ref_clock_out_oe <= 1'b0;
      end else begin
         ref_clock_out_oe <= ctrl_ff[RCOS_OE_BIT];
         ref_clock_out_pin <= ctrl_ff[RCOS_OE_BIT] & ref_ff;
      end
   end
   // ----------------------------------------------------------------
   // Oscillator readiness status
   // ----------------------------------------------------------------
   // Registered copy; unimplemented positions forced to zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stat_ff <= 8'h00;
      end else begin
         stat_ff <= {pll_lock_flag, 1'b0, low_power_rc_ready, secondary_osc_ready, 1'b0,
                     primary_osc_ready, pll_postscaler_ready, fast_rc_ready} & RCOS_STAT_MASK;
      end
   end
   // ----------------------------------------------------------------
   // Interrupts
   // ----------------------------------------------------------------
   assign evt[RCOS_EVT_SWDONE] = sw_done;
   assign evt[RCOS_EVT_ACTCHG] = active_ff != run_en;
   assign evt[RCOS_EVT_PLLLOSS] = stat_ff[7] && !pll_lock_flag;
   // Sticky bits, write one to clear; a new event wins over the clear
   generate
      for (genvar g = 0; g < RCOS_NEVT; g++) begin : g_irq
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               irq_status_ff[g] <= 1'b0;
            end else if (evt[g]) begin
               irq_status_ff[g] <= 1'b1;
            end else if (wr_irqs && wr_val[g]) begin
               irq_status_ff[g] <= 1'b0;
            end
         end
      end
   endgenerate
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_mask_ff <= '0;
         irq <= 1'b0;
      end else begin
         if (wr_irqm) begin
            irq_mask_ff <= (irq_mask_ff & ~wmask[RCOS_NEVT-1:0]) | wr_val[RCOS_NEVT-1:0];
         end
         irq <= |(irq_status_ff & irq_mask_ff);
      end
   end
   // ----------------------------------------------------------------
   // AXI read channel
   // ----------------------------------------------------------------
   always_comb begin
      rd_val = 32'h0000_0000;
      rd_ok = 1'b1;
      if (s_axi_araddr == RCOS_ADDR_CTRL) begin
         rd_val = ctrl_ff;
         rd_val[RCOS_ACT_BIT] = active_ff;
      end else if (s_axi_araddr == RCOS_ADDR_STAT) begin
         rd_val[7:0] = stat_ff;
      end else if (s_axi_araddr == RCOS_ADDR_IRQ_STATUS) begin
         rd_val[RCOS_NEVT-1:0] = irq_status_ff;
      end else if (s_axi_araddr == RCOS_ADDR_IRQ_MASK) begin
         rd_val[RCOS_NEVT-1:0] = irq_mask_ff;
      end else begin
         rd_ok = 1'b0;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RCOS_RESP_OKAY;
      end else begin
         s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_ok ? RCOS_RESP_OKAY : RCOS_RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   AST_PIN_GATED: assert property (!ctrl_ff[RCOS_OE_BIT] |=> !ref_clock_out_pin)
      else $error("pin driven while output enable is clear");
   AST_OFF_STOPS: assert property (!ctrl_ff[RCOS_ON_BIT] |=> !ref_ff)
      else $error("reference runs while module is off");
   AST_IDLE_STOP: assert property (idle_mode && ctrl_ff[RCOS_STOP_IN_IDLE_BIT] |=> !ref_ff)
      else $error("reference runs in idle with stop bit set");
   AST_SLEEP_OFF: assert property (sleep_mode && !ctrl_ff[RCOS_RUN_IN_SLEEP_BIT] |=> !ref_ff)
      else $error("reference runs in sleep without run-in-sleep");
   AST_SLEEP_ZERO: assert property (sleep_mode && sel == RCOS_SEL_ZERO |=> !ref_ff)
      else $error("run-in-sleep honoured for zero source");
   AST_SWEN_CLEARS: assert property (ctrl_ff[RCOS_SWEN_BIT] && sw_state_ff == RCOS_SW_IDLE
      |-> ##[1:300] !ctrl_ff[RCOS_SWEN_BIT])
      else $error("divider switch never completed");
   AST_DIV_LOAD: assert property (sw_done |=> div_active_ff == $past(div_cfg))
      else $error("divider not loaded on switch");
   AST_ACTIVE: assert property (active_ff == $past(run_en))
      else $error("active status does not follow enable");
   AST_CTRL_ZERO: assert property ((ctrl_ff & ~RCOS_CTRL_WMASK) == 32'h0000_0000)
      else $error("unimplemented control bits set");
   AST_STAT_PLL: assert property (stat_ff[7] == $past(pll_lock_flag) && stat_ff[6] == 1'b0)
      else $error("pll lock status wrong");
   AST_STAT_OSC: assert property (stat_ff[5:4] == $past({low_power_rc_ready, secondary_osc_ready})
      && stat_ff[2:0] == $past({primary_osc_ready, pll_postscaler_ready, fast_rc_ready}))
      else $error("oscillator ready status wrong");
   AST_BYPASS: assert property (run_en && div_active_ff == 15'h0000 |=> ref_ff == $past(src_sel))
      else $error("zero divider does not pass source");
   COV_SWITCH: cover property (sw_done);
   COV_PIN_HIGH: cover property (ref_clock_out_pin && div_active_ff != 15'h0000);
   COV_IRQ: cover property (irq);
   COV_SLEEP_RUN: cover property (sleep_mode && run_en);
endmodule

// [dv/rcos_ref_rx.sv]
// Far-side receiver of the reference clock pin: counts edges and times the period
`timescale 1ns/1ns
module rcos_ref_rx (
   // Bus clock
   input wire logic aclk,
   // Pin and its driver enable
   input wire logic ref_clock_out_pin,
   input wire logic ref_clock_out_oe,
   // Measurements
   output int edge_cnt,
   output int period,
   output int bad_drive
);
   logic prev = 1'b0;
   int since = 0;
   // Time between rising edges; a high pin with its driver off is counted
   always @(posedge aclk) begin
      prev <= ref_clock_out_pin;
      since <= since + 1;
      if (ref_clock_out_pin === 1'b1 && prev === 1'b0) begin
         edge_cnt <= edge_cnt + 1;
         period <= since + 1;
         since <= 0;
      end
      if (ref_clock_out_oe === 1'b0 && ref_clock_out_pin === 1'b1) begin
         bad_drive <= bad_drive + 1;
      end
   end
endmodule

// [dv/tb_rcos_refclk.sv]
// Self-checking bench of the reference clock block: registers, pin, low power and interrupts
`timescale 1ns/1ns
module tb_rcos_refclk import rcos_pkg::*;;
   // ------------
   // Declarations
   // ------------
   typedef struct {logic [31:0] data; logic [31:0] msk; logic [1:0] resp; string nm;} rcos_exp_s;
   localparam logic [31:0] ALL = 32'hffffffff;
   localparam logic [31:0] B_ON = 32'h1 << RCOS_ON_BIT;
   localparam logic [31:0] B_OE = 32'h1 << RCOS_OE_BIT;
   localparam logic [31:0] B_SW = 32'h1 << RCOS_SWEN_BIT;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [3:0] s_axi_awaddr = 4'h0;
   logic s_axi_awvalid = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic [3:0] s_axi_araddr = 4'h0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [15:0] src_clk_levels = 16'h0;
   logic idle_mode = 1'b0;
   logic sleep_mode = 1'b0;
   logic [7:0] rdy = 8'h0;
   logic ref_clock_out_pin, ref_clock_out_oe, irq;
   int edge_cnt, period, bad_drive;
   int num_errors = 0;
   int n_checks = 0;
   logic [31:0] rnd = 32'h440b;
   logic [31:0] g;
   rcos_exp_s rq[$];
   logic [1:0] bq[$];
   // Mode table: sel zero, stop in idle, run in sleep, idle, sleep, output expected
   logic [5:0] modes [5] = '{6'b000101, 6'b010100, 6'b001011, 6'b000010, 6'b101010};

   rcos_refclk dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .src_clk_levels(src_clk_levels), .idle_mode(idle_mode), .sleep_mode(sleep_mode),
      .pll_lock_flag(rdy[7]), .low_power_rc_ready(rdy[5]), .secondary_osc_ready(rdy[4]),
      .primary_osc_ready(rdy[2]), .pll_postscaler_ready(rdy[1]), .fast_rc_ready(rdy[0]),
      .ref_clock_out_pin(ref_clock_out_pin), .ref_clock_out_oe(ref_clock_out_oe), .irq(irq));

   rcos_ref_rx rx (.aclk(aclk), .ref_clock_out_pin(ref_clock_out_pin), .ref_clock_out_oe(ref_clock_out_oe),
      .edge_cnt(edge_cnt), .period(period), .bad_drive(bad_drive));

   // 25 MHz bus clock
   initial begin
      forever #20 aclk = ~aclk;
   end

   // Source clocks as a counter: bit k has a period of 2^(k+1) bus cycles
   always @(posedge aclk) begin
      src_clk_levels <= src_clk_levels + 16'h1;
   end

   // -----
   // Tasks
   // -----
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
         num_errors++;
      end
   endtask

   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic hang(input string nm);
      $display("MISMATCH %s expected answer seen none", nm);
      num_errors++;
      finish_test();
   endtask

   // Address and data offered together, each released when taken; one spare edge keeps drives apart
   task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er = RCOS_RESP_OKAY);
      int n;
      n = 0;
      bq.push_back(er);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wvalid <= 1'b0;
         end
      end while (!s_axi_bvalid && n < 200);
      s_axi_bready <= 1'b0;
      if (n >= 200) hang("write response");
      @(posedge aclk);
   endtask

   task automatic axi_read(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] msk, input string nm,
                           output logic [31:0] got, input logic [1:0] er = RCOS_RESP_OKAY);
      int n;
      n = 0;
      rq.push_back('{exp, msk, er, nm});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arvalid <= 1'b0;
         end
      end while (!s_axi_rvalid && n < 200);
      got = s_axi_rdata;
      s_axi_rready <= 1'b0;
      if (n >= 200) hang("read data");
      @(posedge aclk);
   endtask

   // Response watcher: each answer is compared with the oldest note of its channel
   always @(posedge aclk) begin
      rcos_exp_s e;
      if (s_axi_rvalid && s_axi_rready && rq.size() > 0) begin
         e = rq.pop_front();
         check({e.nm, " resp"}, {30'h0, e.resp}, {30'h0, s_axi_rresp});
         if (e.msk != 32'h0) begin
            check(e.nm, e.data & e.msk, s_axi_rdata & e.msk);
         end
      end
      if (s_axi_bvalid && s_axi_bready && bq.size() > 0) begin
         check("bresp", {30'h0, bq.pop_front()}, {30'h0, s_axi_bresp});
      end
   end

   task automatic poll(input int b, input logic v);
      int n;
      logic [31:0] got;
      n = 0;
      do begin
         axi_read(RCOS_ADDR_CTRL, 32'h0, 32'h0, "poll", got);
         n++;
      end while (got[b] !== v && n < 50);
      if (got[b] !== v) hang("ctrl poll");
   endtask

   // Divider loaded while stopped, select only moved while inactive, no write while enable and active differ
   task automatic start_ref(input logic [31:0] c);
      axi_write(RCOS_ADDR_CTRL, c | B_SW);
      poll(RCOS_SWEN_BIT, 1'b0);
      axi_write(RCOS_ADDR_CTRL, c | B_ON);
      poll(RCOS_ACT_BIT, 1'b1);
   endtask

   task automatic stop_ref(input logic [31:0] c);
      axi_write(RCOS_ADDR_CTRL, c);
      poll(RCOS_ACT_BIT, 1'b0);
   endtask

   task automatic edges(input int cyc, output int e);
      int c0;
      c0 = edge_cnt;
      repeat (cyc) @(posedge aclk);
      e = edge_cnt - c0;
   endtask

   // --------
   // Sequence
   // --------
   initial begin
      int d;
      int e;
      logic [31:0] c;
      logic [5:0] m;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      axi_read(RCOS_ADDR_CTRL, 32'h0, ALL, "ctrl reset", g);
      axi_read(RCOS_ADDR_IRQ_MASK, 32'h0, ALL, "mask reset", g);
      axi_write(RCOS_ADDR_CTRL, 32'hffff7fff);
      poll(RCOS_SWEN_BIT, 1'b0);
      axi_read(RCOS_ADDR_CTRL, 32'h7fff380f, ALL, "ctrl fields", g);
      axi_write(4'h2, 32'h0, RCOS_RESP_SLVERR);
      axi_read(4'h2, 32'h0, ALL, "unmapped", g, RCOS_RESP_SLVERR);
      $display("test registers done");
      axi_write(RCOS_ADDR_STAT, ALL);
      for (int i = 0; i < 4; i++) begin
         rnd = lfsr(rnd);
         rdy <= rnd[7:0];
         repeat (4) @(posedge aclk);
         axi_read(RCOS_ADDR_STAT, rnd & 32'hb7, ALL, "clock status", g);
      end
      rdy <= 8'hff;
      $display("test status done");
      for (int i = 0; i < 3; i++) begin
         rnd = lfsr(rnd);
         d = (i < 2) ? i : 2 + int'(rnd[1:0]);
         c = (32'(d) << RCOS_DIV_LSB) | B_OE | 32'h1;
         start_ref(c);
         edges(40 * d + 48, e);
         check("ref period", (d == 0) ? 32'd4 : 32'(8 * d), 32'(period));
         axi_write(RCOS_ADDR_CTRL, (c & ~B_OE) | B_ON);
         edges(64, e);
         check("edges with pin off", 32'h0, 32'(e));
         check("pin enable", 32'h0, {31'h0, ref_clock_out_oe});
         stop_ref(c & ~B_OE);
      end
      check("pin driven while off", 32'h0, 32'(bad_drive));
      $display("test divider done");
      for (int i = 0; i < 5; i++) begin
         m = modes[i];
         c = (32'h1 << RCOS_DIV_LSB) | B_OE | {31'h0, ~m[5]} | (32'(m[4]) << RCOS_STOP_IN_IDLE_BIT);
         c = c | (32'(m[3]) << RCOS_RUN_IN_SLEEP_BIT);
         start_ref(c);
         idle_mode <= m[2];
         sleep_mode <= m[1];
         repeat (4) @(posedge aclk);
         edges(64, e);
         check("output in low power", {31'h0, m[0]}, {31'h0, e > 0});
         axi_read(RCOS_ADDR_CTRL, {23'h0, m[0], 8'h0}, 32'h100, "active in low power", g);
         idle_mode <= 1'b0;
         sleep_mode <= 1'b0;
         poll(RCOS_ACT_BIT, 1'b1);
         stop_ref(c);
      end
      $display("test low power done");
      axi_read(RCOS_ADDR_IRQ_STATUS, 32'h3, 32'h3, "events seen", g);
      check("irq while masked", 32'h0, {31'h0, irq});
      axi_write(RCOS_ADDR_IRQ_MASK, 32'h2);
      repeat (2) @(posedge aclk);
      check("irq raised", 32'h1, {31'h0, irq});
      axi_write(RCOS_ADDR_IRQ_STATUS, 32'h2);
      repeat (2) @(posedge aclk);
      check("irq after clear", 32'h0, {31'h0, irq});
      axi_read(RCOS_ADDR_IRQ_STATUS, 32'h1, 32'h3, "one event cleared", g);
      axi_write(RCOS_ADDR_IRQ_STATUS, 32'h7);
      axi_read(RCOS_ADDR_IRQ_STATUS, 32'h0, ALL, "all cleared", g);
      axi_write(RCOS_ADDR_IRQ_MASK, 32'h4);
      rdy <= 8'h7f;
      repeat (4) @(posedge aclk);
      check("irq on lock loss", 32'h1, {31'h0, irq});
      axi_read(RCOS_ADDR_IRQ_STATUS, 32'h4, ALL, "lock loss event", g);
      $display("test interrupts done");
      finish_test();
   end
endmodule
